//--- rtl/stop_protection_soft_limit.sv
`timescale 1ns/1ns
// Operation
// - power-fail enabled: decelerate, do not coast
// - power-fail enable 0/1, default off, immediate
// - supply back quickly: resume previous state
// - power-fail stop uses power-fail decel time
// - fault method 0: cut current, coast
// - fault method 1: drive to zero, then free
// - fault method 2: emergency torque, then free
// - emergency torque 0..5000, default 1000
// - overtravel inputs ignored by default; 0 enables
// - overtravel method 0: coast, then lock
// - overtravel method 1: decelerate, then lock
// - overtravel method 2: torque, lock one direction
// - coasting stop uses no decel time
// - decel from local or network quick-stop setting
// - soft-limit mode off, always, after homing
// - signed 32-bit limits, extreme defaults
// - soft limits in every control mode
// - position out of range: warn and stop
// - homing-complete status output
module stop_protection_soft_limit
  import stop_prot_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic positive_drive_inhibit,
  input wire logic negative_drive_inhibit,
  input wire logic mains_lost,
  input wire logic class2_fault,
  input wire logic homing_done,
  input wire logic motor_running,
  input wire logic zero_speed,
  input wire logic network_cmd,
  input wire logic [15:0] net_quick_stop_decel,
  input wire logic signed [31:0] feedback_position_cmd_units,
  output stop_kind_e stop_kind,
  output logic torque_off,
  output logic [15:0] stop_decel_time,
  output logic [15:0] stop_torque_limit,
  output logic lock_pos,
  output logic lock_neg,
  output logic overtravel_warning,
  output logic homing_complete
);

  // pin synchronisers: first stage is read only by the second
  logic [4:0] sync1;
  logic [4:0] sync2;
  wire [4:0] pins_raw = {homing_done, class2_fault, mains_lost, negative_drive_inhibit, positive_drive_inhibit};
  wire pos_inh = sync2[0];
  wire neg_inh = sync2[1];
  wire mains_off = sync2[2];
  wire fault = sync2[3];
  wire homed = sync2[4];

  // settings
  logic [15:0] power_fail_protect_enable;
  logic [15:0] power_fail_decel_time;
  logic [15:0] fault_stop_method; // written value
  logic [15:0] overtravel_input_select;
  logic [15:0] overtravel_stop_method;
  logic [15:0] emergency_stop_torque;
  logic [15:0] soft_limit_mode;
  logic signed [31:0] positive_soft_limit;
  logic signed [31:0] negative_soft_limit;
  logic [15:0] local_stop_decel_time;
  // copies in force; only refreshed while the motor is not driven
  logic [1:0] fault_method_act;
  logic ot_input_act;
  logic [1:0] ot_method_act;

  // state
  sup_state_e state;
  sup_state_e next_state;
  sup_state_e resume_state; // state held before a dropout
  logic ot_dir_pos; // direction that tripped overtravel

  // write decode
  wire wr_pf_en = reg_wr && (reg_addr == ADDR_PF_ENABLE);
  wire wr_pf_dec = reg_wr && (reg_addr == ADDR_PF_DECEL);
  wire wr_fault = reg_wr && (reg_addr == ADDR_FAULT_STOP);
  wire wr_ot_in = reg_wr && (reg_addr == ADDR_OT_INPUT);
  wire wr_ot_stop = reg_wr && (reg_addr == ADDR_OT_STOP);
  wire wr_torque = reg_wr && (reg_addr == ADDR_ESTOP_TORQUE);
  wire wr_soft = reg_wr && (reg_addr == ADDR_SOFT_MODE);
  wire wr_pos = reg_wr && (reg_addr == ADDR_POS_LIMIT);
  wire wr_neg = reg_wr && (reg_addr == ADDR_NEG_LIMIT);
  wire wr_local = reg_wr && (reg_addr == ADDR_LOCAL_DECEL);
  wire [15:0] wlo = reg_wdata[15:0];
  // out-of-range values are refused and the old setting kept
  wire ok_flag = wlo <= MAX_FLAG;
  wire ok_method = wlo <= MAX_METHOD;
  wire ok_pf_dec = wlo <= MAX_PF_DECEL;
  wire ok_torque = wlo <= MAX_ESTOP_TORQUE;

  // soft-limit check armed per mode, in every control mode
  wire soft_armed = (soft_limit_mode == 16'h0001) ||
                    ((soft_limit_mode == 16'h0002) && homed);
  wire over_pos = feedback_position_cmd_units > positive_soft_limit;
  wire over_neg = feedback_position_cmd_units < negative_soft_limit;
  // position outside the window, whether or not the motor turns;
  // the hold state needs this, since a stopped motor never trips
  wire soft_out = soft_armed && (over_pos || over_neg);
  wire soft_trip = soft_out && motor_running;
  // hardware drive-inhibit inputs count only when selected
  wire hw_pos = !ot_input_act && pos_inh;
  wire hw_neg = !ot_input_act && neg_inh;
  wire ot_trip = hw_pos || hw_neg || soft_trip;
  wire ot_pos = hw_pos || (soft_trip && over_pos);
  // overtravel still present; keeps the shaft locked until it clears
  wire ot_level = hw_pos || hw_neg || soft_out;
  wire pf_on = power_fail_protect_enable[0];
  // motor not driven: settings may be taken over
  // the free state counts too, since current is already off there
  wire idle = !motor_running && ((state == ST_RUN) || (state == ST_FREE));
  // decel source for zero-speed and torque stops
  wire [15:0] qs_decel = network_cmd ? net_quick_stop_decel : local_stop_decel_time;

  // synchroniser flops
  // a pin that changes near the edge may leave sync1 unsettled,
  // so only sync2 is ever read by the logic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  // register writes; changes apply at once unless noted
  // limits take any 32-bit pattern and are never refused; a crossed
  // pair simply leaves every position out of range
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_fail_protect_enable <= RST_PF_ENABLE;
      power_fail_decel_time <= RST_PF_DECEL;
      fault_stop_method <= RST_FAULT_STOP;
      overtravel_input_select <= RST_OT_INPUT;
      overtravel_stop_method <= RST_OT_STOP;
      emergency_stop_torque <= RST_ESTOP_TORQUE;
      soft_limit_mode <= RST_SOFT_MODE;
      positive_soft_limit <= RST_POS_LIMIT;
      negative_soft_limit <= RST_NEG_LIMIT;
      local_stop_decel_time <= RST_LOCAL_DECEL;
    end else begin
      if (wr_pf_en && ok_flag) power_fail_protect_enable <= wlo;
      if (wr_pf_dec && ok_pf_dec) power_fail_decel_time <= wlo;
      if (wr_fault && ok_method) fault_stop_method <= wlo;
      if (wr_ot_in && ok_flag) overtravel_input_select <= wlo;
      if (wr_ot_stop && ok_method) overtravel_stop_method <= wlo;
      if (wr_torque && ok_torque) emergency_stop_torque <= wlo;
      if (wr_soft && ok_method) soft_limit_mode <= wlo;
      if (wr_pos) positive_soft_limit <= reg_wdata;
      if (wr_neg) negative_soft_limit <= reg_wdata;
      if (wr_local) local_stop_decel_time <= wlo;
    end
  end

  // method settings take effect only with the motor at rest
  // switching stop style in mid-stop would leave the loop half-way
  // between two behaviours, hence the deferral
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fault_method_act <= RST_FAULT_STOP[1:0];
      ot_input_act <= RST_OT_INPUT[0];
      ot_method_act <= RST_OT_STOP[1:0];
    end else if (idle) begin
      fault_method_act <= fault_stop_method[1:0];
      ot_input_act <= overtravel_input_select[0];
      ot_method_act <= overtravel_stop_method[1:0];
    end
  end

  // supervisor transitions; fault wins over mains loss over overtravel
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (fault) begin
          next_state = ST_FAULT_STOP;
        end else if (mains_off && pf_on && motor_running) begin
          next_state = ST_PF_STOP;
        end else if (ot_trip) begin
          next_state = ST_OT_STOP;
        end
      end
      ST_PF_STOP: begin
        if (fault) begin
          next_state = ST_FAULT_STOP;
        end else if (!mains_off) begin
          next_state = resume_state;
        end
      end
      ST_FAULT_STOP: begin
        // method 0 drops to free at once, others after standstill
        if (fault_method_act == 2'b00 || zero_speed) begin
          next_state = ST_FREE;
        end
      end
      ST_FREE: begin
        if (!fault) begin
          next_state = ST_RUN;
        end
      end
      ST_OT_STOP: begin
        if (fault) begin
          next_state = ST_FAULT_STOP;
        end else if (zero_speed) begin
          next_state = ST_OT_HOLD;
        end
      end
      ST_OT_HOLD: begin
        if (fault) begin
          next_state = ST_FAULT_STOP;
        end else if (!ot_level) begin
          // release only once the pins and the position are back in range
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // state register, remembers where a dropout began
  // the tripping direction is caught on entry so that method 2 still
  // locks the right side once the motor has come to rest
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_RUN;
      resume_state <= ST_RUN;
      ot_dir_pos <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == ST_PF_STOP && state != ST_PF_STOP) resume_state <= state;
      if (state == ST_RUN && next_state == ST_OT_STOP) ot_dir_pos <= ot_pos;
    end
  end

  // outputs to the control loop, registered
  // decoded from next_state so the outputs land together with the
  // state change rather than one cycle behind it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stop_kind <= STOP_NONE;
      torque_off <= 1'b0;
      stop_decel_time <= 16'h0000;
      stop_torque_limit <= RST_ESTOP_TORQUE;
      lock_pos <= 1'b0;
      lock_neg <= 1'b0;
      overtravel_warning <= 1'b0;
      homing_complete <= 1'b0;
    end else begin
      homing_complete <= homed;
      overtravel_warning <= soft_trip || ((state == ST_OT_STOP || state == ST_OT_HOLD) && soft_armed &&
                            (over_pos || over_neg));
      stop_torque_limit <= emergency_stop_torque;
      case (next_state)
        ST_PF_STOP: begin
          stop_kind <= STOP_DECEL;
          torque_off <= 1'b0;
          stop_decel_time <= power_fail_decel_time;
          lock_pos <= 1'b0;
          lock_neg <= 1'b0;
        end
        ST_FAULT_STOP: begin
          // coast needs no decel time
          stop_kind <= (fault_method_act == 2'b01) ? STOP_DECEL :
                       (fault_method_act == 2'b10) ? STOP_TORQUE : STOP_COAST;
          torque_off <= fault_method_act == 2'b00;
          stop_decel_time <= (fault_method_act == 2'b00) ? 16'h0000 : qs_decel;
          lock_pos <= 1'b0;
          lock_neg <= 1'b0;
        end
        ST_FREE: begin
          stop_kind <= STOP_COAST;
          torque_off <= 1'b1;
          stop_decel_time <= 16'h0000;
          lock_pos <= 1'b0;
          lock_neg <= 1'b0;
        end
        ST_OT_STOP: begin
          stop_kind <= (ot_method_act == 2'b01) ? STOP_DECEL :
                       (ot_method_act == 2'b10) ? STOP_TORQUE : STOP_COAST;
          torque_off <= ot_method_act == 2'b00;
          stop_decel_time <= (ot_method_act == 2'b00) ? 16'h0000 : qs_decel;
          lock_pos <= 1'b0;
          lock_neg <= 1'b0;
        end
        ST_OT_HOLD: begin
          // methods 0/1 lock the shaft, 2 locks only the tripped side
          stop_kind <= STOP_NONE;
          torque_off <= 1'b0;
          stop_decel_time <= 16'h0000;
          lock_pos <= (ot_method_act != 2'b10) || ot_dir_pos;
          lock_neg <= (ot_method_act != 2'b10) || !ot_dir_pos;
        end
        default: begin
          stop_kind <= STOP_NONE;
          torque_off <= 1'b0;
          stop_decel_time <= 16'h0000;
          lock_pos <= 1'b0;
          lock_neg <= 1'b0;
        end
      endcase
    end
  end

  // read mux; unmapped reads give zero
  // status is built from the registered outputs plus the power-fail state bit, so software sees
  // exactly what the control loop is being told
  logic [31:0] next_rdata;
  wire [31:0] status_word = {25'h0000000, state == ST_PF_STOP, torque_off, lock_neg, lock_pos,
                             homing_complete, overtravel_warning, stop_kind != STOP_NONE};
  always_comb begin
    if (reg_addr == ADDR_PF_ENABLE) next_rdata = {16'h0000, power_fail_protect_enable};
    else if (reg_addr == ADDR_PF_DECEL) next_rdata = {16'h0000, power_fail_decel_time};
    else if (reg_addr == ADDR_FAULT_STOP) next_rdata = {16'h0000, fault_stop_method};
    else if (reg_addr == ADDR_OT_INPUT) next_rdata = {16'h0000, overtravel_input_select};
    else if (reg_addr == ADDR_OT_STOP) next_rdata = {16'h0000, overtravel_stop_method};
    else if (reg_addr == ADDR_ESTOP_TORQUE) next_rdata = {16'h0000, emergency_stop_torque};
    else if (reg_addr == ADDR_SOFT_MODE) next_rdata = {16'h0000, soft_limit_mode};
    else if (reg_addr == ADDR_POS_LIMIT) next_rdata = positive_soft_limit;
    else if (reg_addr == ADDR_NEG_LIMIT) next_rdata = negative_soft_limit;
    else if (reg_addr == ADDR_LOCAL_DECEL) next_rdata = {16'h0000, local_stop_decel_time};
    else if (reg_addr == ADDR_STATUS) next_rdata = status_word;
    else next_rdata = 32'h00000000;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) reg_rdata <= 32'h00000000;
    else if (reg_rd) reg_rdata <= next_rdata;
    else reg_rdata <= 32'h00000000;
  end

endmodule

//--- rtl/stop_prot_pkg.sv
package stop_prot_pkg;
  // register offsets on the plain register port (word index)
  localparam logic [3:0] ADDR_PF_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_PF_DECEL = 4'h1;
  localparam logic [3:0] ADDR_FAULT_STOP = 4'h2;
  localparam logic [3:0] ADDR_OT_INPUT = 4'h3;
  localparam logic [3:0] ADDR_OT_STOP = 4'h4;
  localparam logic [3:0] ADDR_ESTOP_TORQUE = 4'h5;
  localparam logic [3:0] ADDR_SOFT_MODE = 4'h6;
  localparam logic [3:0] ADDR_POS_LIMIT = 4'h7;
  localparam logic [3:0] ADDR_NEG_LIMIT = 4'h8;
  localparam logic [3:0] ADDR_LOCAL_DECEL = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  // reset values
  localparam logic [15:0] RST_PF_ENABLE = 16'h0000;
  localparam logic [15:0] RST_PF_DECEL = 16'h0014;
  localparam logic [15:0] RST_FAULT_STOP = 16'h0000;
  localparam logic [15:0] RST_OT_INPUT = 16'h0001;
  localparam logic [15:0] RST_OT_STOP = 16'h0000;
  localparam logic [15:0] RST_ESTOP_TORQUE = 16'h03E8;
  localparam logic [15:0] RST_SOFT_MODE = 16'h0000;
  localparam logic [31:0] RST_POS_LIMIT = 32'h7FFFFFFF;
  localparam logic [31:0] RST_NEG_LIMIT = 32'h80000000;
  localparam logic [15:0] RST_LOCAL_DECEL = 16'h0000;
  // setting ranges
  localparam logic [15:0] MAX_PF_DECEL = 16'h2710;
  localparam logic [15:0] MAX_ESTOP_TORQUE = 16'h1388;
  localparam logic [15:0] MAX_METHOD = 16'h0002;
  localparam logic [15:0] MAX_FLAG = 16'h0001;
  // status register bit positions
  localparam int ST_STOP_ACTIVE = 0;
  localparam int ST_OT_WARN = 1;
  localparam int ST_HOMED = 2;
  localparam int ST_LOCK_POS = 3;
  localparam int ST_LOCK_NEG = 4;
  localparam int ST_TORQUE_OFF = 5;
  localparam int ST_PF_ACTIVE = 6;
  // stop styles driven to the control loop
  typedef enum logic [1:0] {
    STOP_NONE = 2'b00,
    STOP_COAST = 2'b01,
    STOP_DECEL = 2'b10,
    STOP_TORQUE = 2'b11
  } stop_kind_e;
  // supervisor states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PF_STOP = 3'b001,
    ST_FAULT_STOP = 3'b010,
    ST_FREE = 3'b011,
    ST_OT_STOP = 3'b100,
    ST_OT_HOLD = 3'b101
  } sup_state_e;
endpackage

//--- dv/stop_prot_monitor.sv
`timescale 1ns/1ns
module stop_prot_monitor
  import stop_prot_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic class2_fault,
  input wire logic homing_done,
  input wire stop_kind_e stop_kind,
  input wire logic torque_off,
  input wire logic [15:0] stop_decel_time,
  input wire logic [15:0] stop_torque_limit,
  input wire logic lock_pos,
  input wire logic overtravel_warning,
  input wire logic homing_complete
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer cycle");
  chk_coast_nodecel: assert property (stop_kind inside {STOP_NONE, STOP_COAST} |-> stop_decel_time == 16'h0)
    else $error("decel time given while coasting or idle");
  chk_free_coast: assert property (torque_off |-> stop_kind == STOP_COAST)
    else $error("current cut while a driven stop is requested");
  chk_homed_rise: assert property ($rose(homing_done) ##1 homing_done [*5] |-> homing_complete)
    else $error("homing complete late");
  chk_homed_fall: assert property (!homing_done [*6] |-> !homing_complete)
    else $error("homing complete without homing done");
  chk_fault_stops: assert property (class2_fault [*6] |-> stop_kind != STOP_NONE)
    else $error("fault did not stop the motor");
  chk_warn_stop: assert property ($rose(overtravel_warning) |-> ##[0:2] stop_kind != STOP_NONE)
    else $error("soft limit warning without stop");
  chk_torque_max: assert property (stop_kind == STOP_TORQUE |-> stop_torque_limit <= MAX_ESTOP_TORQUE)
    else $error("emergency torque above range");
  // main scenarios reached
  cover property (stop_kind == STOP_TORQUE && lock_pos == 1'b0);
  cover property (torque_off);
  cover property (overtravel_warning);
endmodule
bind stop_protection_soft_limit stop_prot_monitor mon (.*);

//--- dv/motor_model.sv
`timescale 1ns/1ns
// control loop and motor: spins while allowed, coasts or brakes down otherwise
module motor_model
  import stop_prot_pkg::*;
#(
  parameter int SPIN = 12
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run_cmd,
  input wire stop_kind_e stop_kind,
  input wire logic torque_off,
  output logic motor_running,
  output logic zero_speed
);
  logic [7:0] speed; // abstract speed, counts down to rest
  wire drive_ok = run_cmd && stop_kind == STOP_NONE && !torque_off;
  // any stop style simply bleeds speed; slow enough to sample mid-stop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) speed <= 8'h00;
    else if (drive_ok) speed <= SPIN[7:0];
    else if (speed != 8'h00) speed <= speed - 8'h01;
  end
  assign motor_running = speed != 8'h00;
  assign zero_speed = speed == 8'h00;
endmodule

//--- dv/stop_protection_soft_limit_tb.sv
`timescale 1ns/1ns
module stop_protection_soft_limit_tb;
  import stop_prot_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, positive_drive_inhibit = 1'b0, negative_drive_inhibit = 1'b0;
  logic mains_lost = 1'b0, class2_fault = 1'b0, homing_done = 1'b0, network_cmd = 1'b0, run_cmd = 1'b0;
  logic [15:0] net_quick_stop_decel = 16'h0456;
  logic signed [31:0] feedback_position_cmd_units = 32'sh0;
  logic [31:0] reg_rdata;
  logic motor_running, zero_speed, torque_off, lock_pos, lock_neg, overtravel_warning, homing_complete;
  logic [15:0] stop_decel_time, stop_torque_limit;
  stop_kind_e stop_kind;
  int mismatches = 0, compares = 0, cycles = 0, i, k;
  // reset rows: address, expected value; last row is unmapped
  logic [35:0] rst_rows [10] = '{{4'h0, 32'h0}, {4'h1, 32'h14}, {4'h2, 32'h0}, {4'h3, 32'h1}, {4'h4, 32'h0},
    {4'h5, 32'h3E8}, {4'h6, 32'h0}, {4'h7, 32'h7FFFFFFF}, {4'h8, 32'h80000000}, {4'hB, 32'h0}};
  // fault rows: method, network, stop kind, current cut, decel time
  logic [21:0] flt_rows [3] = '{{2'h0, 1'h0, STOP_COAST, 1'h1, 16'h0}, {2'h1, 1'h0, STOP_DECEL, 1'h0, 16'h0123},
    {2'h2, 1'h1, STOP_TORQUE, 1'h0, 16'h0456}};
  stop_protection_soft_limit uut (.*);
  motor_model motor (.*);
  always #25 ref_clk = ~ref_clk;
  // hang guard, well above the planned run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read answer stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_kind(input stop_kind_e exp);
    chk("stop_kind", {30'h0, stop_kind}, {30'h0, exp});
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("stop_torque_limit", {16'h0, stop_torque_limit}, 32'h3E8);
    for (i = 0; i < 10; i++) rdc(rst_rows[i][35:32], rst_rows[i][31:0]);
    // out-of-range writes leave the old value, boundary values land
    wr(ADDR_FAULT_STOP, 32'h3);
    rdc(ADDR_FAULT_STOP, 32'h0);
    wr(ADDR_PF_DECEL, 32'h2711);
    rdc(ADDR_PF_DECEL, 32'h14);
    wr(ADDR_ESTOP_TORQUE, 32'h1388);
    rdc(ADDR_ESTOP_TORQUE, 32'h1388);
    wr(ADDR_NEG_LIMIT, 32'hFFFFFC18);
    rdc(ADDR_NEG_LIMIT, 32'hFFFFFC18);
    wr(ADDR_LOCAL_DECEL, 32'h0123);
    rdc(ADDR_LOCAL_DECEL, 32'h0123);
    wr(ADDR_ESTOP_TORQUE, 32'h01F4);
    // each fault stop method, method written with the motor at rest
    for (i = 0; i < 3; i++) begin
      wr(ADDR_FAULT_STOP, {30'h0, flt_rows[i][21:20]});
      network_cmd <= flt_rows[i][19];
      run_cmd <= 1'b1;
      settle(4);
      @(posedge ref_clk);
      class2_fault <= 1'b1;
      settle(6);
      chk_kind(stop_kind_e'(flt_rows[i][18:17]));
      chk("torque_off", {31'h0, torque_off}, {31'h0, flt_rows[i][16]});
      chk("stop_decel_time", {16'h0, stop_decel_time}, {16'h0, flt_rows[i][15:0]});
      if (i == 2) chk("stop_torque_limit", {16'h0, stop_torque_limit}, 32'h01F4);
      k = 0;
      while (torque_off !== 1'b1 && k < 60) begin
        settle(1);
        k++;
      end
      chk_kind(STOP_COAST);
      @(posedge ref_clk);
      run_cmd <= 1'b0;
      class2_fault <= 1'b0;
      network_cmd <= 1'b0;
      settle(8);
      chk_kind(STOP_NONE);
    end
    // power loss while running, then a quick return of supply
    wr(ADDR_PF_DECEL, 32'h1E);
    wr(ADDR_PF_ENABLE, 32'h1);
    run_cmd <= 1'b1;
    settle(4);
    @(posedge ref_clk);
    mains_lost <= 1'b1;
    settle(6);
    chk_kind(STOP_DECEL);
    chk("stop_decel_time", {16'h0, stop_decel_time}, 32'h1E);
    @(posedge ref_clk);
    mains_lost <= 1'b0;
    settle(6);
    chk_kind(STOP_NONE);
    // inhibit pins ignored by default
    @(posedge ref_clk);
    positive_drive_inhibit <= 1'b1;
    settle(6);
    chk_kind(STOP_NONE);
    @(posedge ref_clk);
    positive_drive_inhibit <= 1'b0;
    run_cmd <= 1'b0;
    settle(16);
    wr(ADDR_OT_INPUT, 32'h0);
    wr(ADDR_OT_STOP, 32'h2);
    run_cmd <= 1'b1;
    settle(4);
    @(posedge ref_clk);
    negative_drive_inhibit <= 1'b1;
    settle(6);
    chk_kind(STOP_TORQUE);
    // locks appear only once the brake has brought the motor to rest
    settle(12);
    chk("locks", {30'h0, lock_pos, lock_neg}, 32'h1);
    rdc(ADDR_STATUS, 32'h10);
    @(posedge ref_clk);
    negative_drive_inhibit <= 1'b0;
    run_cmd <= 1'b0;
    settle(16);
    // soft limit only after homing, decelerating stop
    wr(ADDR_OT_STOP, 32'h1);
    wr(ADDR_POS_LIMIT, 32'h3E8);
    wr(ADDR_SOFT_MODE, 32'h2);
    feedback_position_cmd_units <= 32'sh7D0;
    run_cmd <= 1'b1;
    settle(8);
    chk("overtravel_warning", {31'h0, overtravel_warning}, 32'h0);
    @(posedge ref_clk);
    homing_done <= 1'b1;
    settle(8);
    chk("homing_complete", {31'h0, homing_complete}, 32'h1);
    chk("overtravel_warning", {31'h0, overtravel_warning}, 32'h1);
    chk_kind(STOP_DECEL);
    rdc(ADDR_STATUS, 32'h7);
    // reset in mid-run: stop request dropped, settings back to defaults
    @(posedge ref_clk);
    rst_n <= 1'b0;
    settle(2);
    chk_kind(STOP_NONE);
    chk("overtravel_warning", {31'h0, overtravel_warning}, 32'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ADDR_SOFT_MODE, 32'h0);
    rdc(ADDR_NEG_LIMIT, 32'h80000000);
    results();
  end
endmodule
